/* File: shared/pkh_pkg.sv */
/*
 * Shared constants and types of the packet handler configuration block.
 * Assumes a 32-bit AXI4-Lite register bus and a packet engine on the same clock.
 */
package pkh_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_PAYLOAD_LEN = 6'h1C;
	localparam logic [5:0] IDX_NODE_ADDR   = 6'h1D;
	localparam logic [5:0] IDX_PKT_CFG     = 6'h1E;
	localparam logic [5:0] IDX_FIFO_CRC    = 6'h1F;
	localparam logic [5:0] IDX_IRQ_STAT    = 6'h20;
	localparam logic [5:0] IDX_IRQ_MASK    = 6'h21;

	// Reset values
	localparam logic [7:0] RST_PKT_CFG  = 8'h48;
	localparam logic [7:0] RST_FIFO_CRC = 8'h00;
	localparam logic [7:0] RST_BYTE     = 8'h00;

	// packet_config fields
	localparam int PC_LEN_FMT = 7;
	localparam int PC_PRE_LO  = 5;
	localparam int PC_WHITEN  = 4;
	localparam int PC_CRC_EN  = 3;
	localparam int PC_FILT_LO = 1;
	localparam int PC_CRC_OK  = 0;
	// fifo_crc_config fields; bits 5..0 reserved, read as zero
	localparam int FC_AUTOFLUSH_DIS = 7;
	localparam int FC_FIFO_DIR      = 6;
	localparam logic [7:0] FC_WR_MASK = 8'hC0;
	localparam logic [7:0] PC_WR_MASK = 8'hFE;

	// Broadcast addresses accepted by the wider filter modes
	localparam logic [7:0] ADDR_ZERO = 8'h00;
	localparam logic [7:0] ADDR_ONES = 8'hFF;

	// Interrupt status bits
	localparam int IRQ_W        = 4;
	localparam int IRQ_CRC_OK   = 0;
	localparam int IRQ_CRC_FAIL = 1;
	localparam int IRQ_ADDR_REJ = 2;
	localparam int IRQ_LEN_REJ  = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PKH_FILT_OFF  = 2'b00,
		PKH_FILT_NODE = 2'b01,
		PKH_FILT_ZERO = 2'b10,
		PKH_FILT_BOTH = 2'b11
	} pkh_filt_mode_t;

	// Settings handed to the packet engine
	typedef struct packed {
		logic           len_fixed;
		logic [2:0]     preamble_bytes;
		logic           whiten_en;
		logic           crc_proc_en;
		pkh_filt_mode_t addr_filter_mode;
	} pkh_cfg_t;

	// End of a received packet
	typedef struct packed {
		logic valid;
		logic crc_pass;
	} pkh_rx_end_t;

endpackage : pkh_pkg

/* File: src/pkh_addr_filter.sv */
/*
 * Received address filter: one accept or reject pulse per offered address.
 * Assumes addresses arrive as one-cycle strobes from logic on clk_i.
 */
module pkh_addr_filter (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire pkh_pkg::pkh_filt_mode_t mode_i,
	input  wire logic [7:0]             node_addr_i,
	input  wire logic                   addr_valid_i,
	input  wire logic [7:0]             addr_i,
	output logic                        accept_o,
	output logic                        reject_o
);

	////////////////////////////////////////////////////////////////////////
	// Match terms and mode selection
	wire logic is_node = (addr_i == node_addr_i);       // see RQ13
	wire logic is_zero = (addr_i == pkh_pkg::ADDR_ZERO);
	wire logic is_ones = (addr_i == pkh_pkg::ADDR_ONES);
	wire logic pass    = (mode_i == pkh_pkg::PKH_FILT_OFF)                       // see RQ5
	                   | (mode_i == pkh_pkg::PKH_FILT_NODE & is_node)            // see RQ5
	                   | (mode_i == pkh_pkg::PKH_FILT_ZERO & (is_node | is_zero)) // see RQ6
	                   | (mode_i == pkh_pkg::PKH_FILT_BOTH & (is_node | is_zero | is_ones)); // see RQ7

	// Verdict is registered so downstream sees a clean pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			accept_o <= 1'b0;
			reject_o <= 1'b0;
		end else begin
			accept_o <= addr_valid_i & pass;
			reject_o <= addr_valid_i & ~pass;
		end
	end

	////////////////////////////////////////////////////////////////////////
	AST_FILT_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ5
		addr_valid_i && mode_i == pkh_pkg::PKH_FILT_OFF |=> accept_o && !reject_o)
		else $error("filter off must accept");
	AST_FILT_NODE: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ13
		addr_valid_i && mode_i != pkh_pkg::PKH_FILT_OFF && addr_i == node_addr_i |=> accept_o)
		else $error("node address rejected");
	AST_FILT_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ6
		addr_valid_i && addr_i == pkh_pkg::ADDR_ZERO && addr_i != node_addr_i |=>
		accept_o == ($past(mode_i) inside {pkh_pkg::PKH_FILT_OFF, pkh_pkg::PKH_FILT_ZERO,
		pkh_pkg::PKH_FILT_BOTH}))
		else $error("zero address verdict wrong");
	AST_FILT_ONES: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ7
		addr_valid_i && addr_i == pkh_pkg::ADDR_ONES && addr_i != node_addr_i && mode_i != pkh_pkg::PKH_FILT_OFF
		|=> reject_o == ($past(mode_i) != pkh_pkg::PKH_FILT_BOTH))
		else $error("ones address verdict wrong");

endmodule : pkh_addr_filter

/* File: src/pkh_packet_cfg.sv */
/*
 * Packet handler configuration and status: AXI4-Lite registers, address
 * filtering, length limit, CRC status, FIFO auto flush and standby access.
 * Assumes the packet engine runs on clk_i and gives one-cycle strobes.
 */
// Our own choice: the AXI4-Lite slave port.
// Functional notes
// RQ1 - Length format bit selects variable or fixed
// RQ2 - Two-bit preamble field gives one to four bytes
// RQ3 - Whitening bit enables whitening and de-whitening
// RQ4 - CRC enable bit controls CRC generate and check
// RQ5 - Filter code 00 off, 01 node only
// RQ6 - Filter code 10 accepts node or 0x00
// RQ7 - Filter code 11 accepts node, 0x00, 0xFF
// RQ8 - Read-only CRC flag: 1 pass, 0 fail
// RQ9 - Auto flush FIFO on CRC fail unless disabled
// RQ10 - Standby FIFO access direction: 1 read, 0 write
// RQ11 - Host leaves reserved low bits at zero
// RQ12 - Payload length: maximum in variable, exact fixed
// RQ13 - Filter compares against eight-bit node address
// RQ14 - CRC flag updated once per packet end
module pkh_packet_cfg #(
	parameter int ADDR_W = 8
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr_i,
	input  wire logic                s_axi_awvalid_i,
	output logic                     s_axi_awready_o,
	input  wire logic [31:0]         s_axi_wdata_i,
	input  wire logic [3:0]          s_axi_wstrb_i,
	input  wire logic                s_axi_wvalid_i,
	output logic                     s_axi_wready_o,
	output logic [1:0]               s_axi_bresp_o,
	output logic                     s_axi_bvalid_o,
	input  wire logic                s_axi_bready_i,
	input  wire logic [ADDR_W-1:0]   s_axi_araddr_i,
	input  wire logic                s_axi_arvalid_i,
	output logic                     s_axi_arready_o,
	output logic [31:0]              s_axi_rdata_o,
	output logic [1:0]               s_axi_rresp_o,
	output logic                     s_axi_rvalid_o,
	input  wire logic                s_axi_rready_i,
	// Packet engine side
	output pkh_pkg::pkh_cfg_t        cfg_o,
	output logic [6:0]               payload_len_o,
	input  wire logic                rx_addr_valid_i,
	input  wire logic [7:0]          rx_addr_i,
	output logic                     addr_accept_o,
	output logic                     addr_reject_o,
	input  wire logic                rx_len_valid_i,
	input  wire logic [7:0]          rx_len_i,
	output logic                     len_reject_o,
	input  wire pkh_pkg::pkh_rx_end_t rx_end_i,
	output logic                     fifo_flush_o,
	input  wire logic                standby_i,
	input  wire logic                fifo_access_i,
	output logic                     fifo_rd_o,
	output logic                     fifo_wr_o,
	output logic                     irq_o
);

	typedef enum logic [0:0] {
		PKH_RD_IDLE = 1'b0,
		PKH_RD_DATA = 1'b1
	} pkh_rd_state_t;

	////////////////////////////////////////////////////////////////////////
	// Register storage
	localparam int IRQ_W_L = pkh_pkg::IRQ_W;
	logic [7:0]         pkt_cfg;
	logic [7:0]         fifo_crc;
	logic [6:0]         payload_len;
	logic [7:0]         node_addr;
	logic [IRQ_W_L-1:0] irq_stat;
	logic [IRQ_W_L-1:0] irq_mask;
	logic               crc_ok_flag;

	// Write channel holding stage and read state
	logic              aw_full;
	logic              w_full;
	logic [5:0]        aw_idx;
	logic [7:0]        w_byte;
	logic              w_lane0;
	pkh_rd_state_t     rd_state;
	pkh_rd_state_t     next_rd_state;

	////////////////////////////////////////////////////////////////////////
	// AXI write side: address and data taken in either order
	assign s_axi_awready_o = ~aw_full;
	assign s_axi_wready_o  = ~w_full;
	wire logic aw_take  = s_axi_awvalid_i & ~aw_full;
	wire logic w_take   = s_axi_wvalid_i & ~w_full;
	// A second write waits while its response is still unanswered
	wire logic wr_fire  = aw_full & w_full & ~s_axi_bvalid_o;
	wire logic wr_pkt   = wr_fire & w_lane0 & (aw_idx == pkh_pkg::IDX_PKT_CFG);
	wire logic wr_fifo  = wr_fire & w_lane0 & (aw_idx == pkh_pkg::IDX_FIFO_CRC);
	wire logic wr_plen  = wr_fire & w_lane0 & (aw_idx == pkh_pkg::IDX_PAYLOAD_LEN);
	wire logic wr_node  = wr_fire & w_lane0 & (aw_idx == pkh_pkg::IDX_NODE_ADDR);
	wire logic wr_stat  = wr_fire & w_lane0 & (aw_idx == pkh_pkg::IDX_IRQ_STAT);
	wire logic wr_mask  = wr_fire & w_lane0 & (aw_idx == pkh_pkg::IDX_IRQ_MASK);
	wire logic wr_hit   = aw_idx inside {pkh_pkg::IDX_PKT_CFG, pkh_pkg::IDX_FIFO_CRC,
		pkh_pkg::IDX_PAYLOAD_LEN, pkh_pkg::IDX_NODE_ADDR, pkh_pkg::IDX_IRQ_STAT,
		pkh_pkg::IDX_IRQ_MASK};

	// Holding registers for address and data beats
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			aw_idx  <= 6'h00;
			w_byte  <= 8'h00;
			w_lane0 <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_full <= 1'b1;
				aw_idx  <= s_axi_awaddr_i[7:2];
			end else if (wr_fire) begin
				aw_full <= 1'b0;
			end
			if (w_take) begin
				w_full  <= 1'b1;
				w_byte  <= s_axi_wdata_i[7:0];
				w_lane0 <= s_axi_wstrb_i[0];
			end else if (wr_fire) begin
				w_full <= 1'b0;
			end
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= pkh_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= wr_hit ? pkh_pkg::RESP_OKAY : pkh_pkg::RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers; crc flag and reserved bits are not writable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pkt_cfg     <= pkh_pkg::RST_PKT_CFG;              // see RQ1
			fifo_crc    <= pkh_pkg::RST_FIFO_CRC;             // see RQ9
			payload_len <= pkh_pkg::RST_BYTE[6:0];
			node_addr   <= pkh_pkg::RST_BYTE;
			irq_mask    <= pkh_pkg::RST_BYTE[IRQ_W_L-1:0];
		end else begin
			if (wr_pkt)
				pkt_cfg <= w_byte & pkh_pkg::PC_WR_MASK;
			// Reserved low bits forced to zero whatever the host writes
			if (wr_fifo)
				fifo_crc <= w_byte & pkh_pkg::FC_WR_MASK;    // see RQ11
			if (wr_plen)
				payload_len <= w_byte[6:0];
			if (wr_node)
				node_addr <= w_byte;                          // see RQ13
			if (wr_mask)
				irq_mask <= w_byte[IRQ_W_L-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Settings decoded for the packet engine
	wire logic autoflush_dis = fifo_crc[pkh_pkg::FC_AUTOFLUSH_DIS];
	wire logic fifo_dir_rd   = fifo_crc[pkh_pkg::FC_FIFO_DIR];
	wire logic len_fixed     = ~pkt_cfg[pkh_pkg::PC_LEN_FMT];  // see RQ1
	wire logic crc_en        = pkt_cfg[pkh_pkg::PC_CRC_EN];
	assign cfg_o.len_fixed        = len_fixed;                  // see RQ1
	// Code n means n+1 bytes of preamble
	assign cfg_o.preamble_bytes   = {1'b0, pkt_cfg[pkh_pkg::PC_PRE_LO +: 2]} + 3'h1; // see RQ2
	assign cfg_o.whiten_en        = pkt_cfg[pkh_pkg::PC_WHITEN]; // see RQ3
	assign cfg_o.crc_proc_en      = crc_en;                       // see RQ4
	assign cfg_o.addr_filter_mode = pkh_pkg::pkh_filt_mode_t'(pkt_cfg[pkh_pkg::PC_FILT_LO +: 2]);
	assign payload_len_o          = payload_len;                  // see RQ12

	////////////////////////////////////////////////////////////////////////
	// Address filter
	pkh_addr_filter u_pkh_addr_filter (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.mode_i       (cfg_o.addr_filter_mode),
		.node_addr_i  (node_addr),
		.addr_valid_i (rx_addr_valid_i),
		.addr_i       (rx_addr_i),
		.accept_o     (addr_accept_o),
		.reject_o     (addr_reject_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Length limit applies only to variable length; fixed uses the exact value
	wire logic len_over  = rx_len_valid_i & ~len_fixed & (rx_len_i > {1'b0, payload_len}); // see RQ12
	// CRC result only counts when checking is on; otherwise the flag holds
	wire logic crc_check = rx_end_i.valid & crc_en;                 // see RQ4
	wire logic crc_fail  = crc_check & ~rx_end_i.crc_pass;
	wire logic flush_now = crc_fail & ~autoflush_dis;               // see RQ9
	wire logic fifo_hit  = standby_i & fifo_access_i;

	// Packet status and strobes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			crc_ok_flag  <= 1'b0;
			len_reject_o <= 1'b0;
			fifo_flush_o <= 1'b0;
			fifo_rd_o    <= 1'b0;
			fifo_wr_o    <= 1'b0;
		end else begin
			if (crc_check)
				crc_ok_flag <= rx_end_i.crc_pass;           // see RQ8 see RQ14
			len_reject_o <= len_over;
			fifo_flush_o <= flush_now;                     // see RQ9
			fifo_rd_o    <= fifo_hit & fifo_dir_rd;        // see RQ10
			fifo_wr_o    <= fifo_hit & ~fifo_dir_rd;       // see RQ10
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt status: a new event wins over a same-cycle write-one clear
	wire logic [IRQ_W_L-1:0] irq_evt = {len_over, addr_reject_o, crc_fail, crc_check & rx_end_i.crc_pass};
	wire logic [IRQ_W_L-1:0] irq_clr = wr_stat ? w_byte[IRQ_W_L-1:0] : {IRQ_W_L{1'b0}};
	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_stat <= pkh_pkg::RST_BYTE[IRQ_W_L-1:0];
		else
			irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
	end
	assign irq_o = |(irq_stat & irq_mask);

	////////////////////////////////////////////////////////////////////////
	// AXI read side
	wire logic [5:0] ar_idx  = s_axi_araddr_i[7:2];
	wire logic       ar_take = s_axi_arvalid_i & (rd_state == PKH_RD_IDLE);
	assign s_axi_arready_o = (rd_state == PKH_RD_IDLE);
	assign s_axi_rvalid_o  = (rd_state == PKH_RD_DATA);
	// Flag byte reads show live packet status in bit 0
	wire logic [7:0] pkt_rd  = pkt_cfg | {7'h00, crc_ok_flag};      // see RQ8
	wire logic       rd_hit  = ar_idx inside {pkh_pkg::IDX_PKT_CFG, pkh_pkg::IDX_FIFO_CRC,
		pkh_pkg::IDX_PAYLOAD_LEN, pkh_pkg::IDX_NODE_ADDR, pkh_pkg::IDX_IRQ_STAT,
		pkh_pkg::IDX_IRQ_MASK};
	wire logic [7:0] rd_byte =
		(ar_idx == pkh_pkg::IDX_PKT_CFG)     ? pkt_rd :
		(ar_idx == pkh_pkg::IDX_FIFO_CRC)    ? fifo_crc :
		(ar_idx == pkh_pkg::IDX_PAYLOAD_LEN) ? {1'b0, payload_len} :
		(ar_idx == pkh_pkg::IDX_NODE_ADDR)   ? node_addr :
		(ar_idx == pkh_pkg::IDX_IRQ_STAT)    ? {4'h0, irq_stat} :
		(ar_idx == pkh_pkg::IDX_IRQ_MASK)    ? {4'h0, irq_mask} : 8'h00;

	// Read state machine
	always_comb begin
		next_rd_state = rd_state;
		case (rd_state)
			PKH_RD_IDLE: begin
				if (s_axi_arvalid_i)
					next_rd_state = PKH_RD_DATA;
			end
			PKH_RD_DATA: begin
				if (s_axi_rready_i)
					next_rd_state = PKH_RD_IDLE;
			end
			default: next_rd_state = PKH_RD_IDLE;
		endcase
	end

	// Read data register, loaded at the address handshake
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_state      <= PKH_RD_IDLE;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= pkh_pkg::RESP_OKAY;
		end else begin
			rd_state <= next_rd_state;
			if (ar_take) begin
				s_axi_rdata_o <= {24'h00_0000, rd_byte};
				s_axi_rresp_o <= rd_hit ? pkh_pkg::RESP_OKAY : pkh_pkg::RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	AST_LEN_FMT: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ1
		wr_pkt |=> cfg_o.len_fixed == !$past(w_byte[pkh_pkg::PC_LEN_FMT]))
		else $error("length format not taken from write");
	AST_PREAMBLE: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ2
		wr_pkt |=> cfg_o.preamble_bytes == {1'b0, $past(w_byte[pkh_pkg::PC_PRE_LO +: 2])} + 3'h1)
		else $error("preamble length wrong");
	AST_WHITEN: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ3
		wr_pkt |=> cfg_o.whiten_en == $past(w_byte[pkh_pkg::PC_WHITEN])
		&& cfg_o.crc_proc_en == $past(w_byte[pkh_pkg::PC_CRC_EN]))
		else $error("whiten or crc enable not taken");
	AST_CRC_FLAG: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ8
		rx_end_i.valid && crc_en |=> crc_ok_flag == $past(rx_end_i.crc_pass))
		else $error("crc flag does not follow result");
	AST_CRC_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ14
		!(rx_end_i.valid && crc_en) |=> $stable(crc_ok_flag))
		else $error("crc flag changed without packet end");
	AST_FLUSH: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ9
		rx_end_i.valid |=> fifo_flush_o == ($past(crc_en) && !$past(rx_end_i.crc_pass)
		&& !$past(autoflush_dis)))
		else $error("auto flush decision wrong");
	AST_FIFO_DIR: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ10
		standby_i && fifo_access_i |=> (fifo_rd_o != fifo_wr_o) && fifo_rd_o == $past(fifo_dir_rd))
		else $error("standby fifo direction wrong");
	AST_LEN_MAX: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ12
		rx_len_valid_i && len_fixed |=> !len_reject_o)
		else $error("length rejected in fixed format");
	AST_RSV_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ11
		wr_fifo |=> (fifo_crc & ~pkh_pkg::FC_WR_MASK) == 8'h00)
		else $error("reserved bits stored");

endmodule : pkh_packet_cfg

/* File: tb/pkh_radio_model.sv */
/*
 * Packet engine stand-in: one-cycle strobes for address, length, packet end
 * and FIFO access. Assumes the caller waits for each call to return.
 */
module pkh_radio_model (
	input  wire logic            clk_i,
	output logic                 addr_valid_o,
	output logic [7:0]           addr_o,
	output logic                 len_valid_o,
	output logic [7:0]           len_o,
	output pkh_pkg::pkh_rx_end_t end_o,
	output logic                 access_o
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////////
	// Idle values; address and length lines carry junk, not zero, so a stale value is never trusted
	initial begin
		addr_valid_o = 1'b0;
		addr_o       = 8'hA5;
		len_valid_o  = 1'b0;
		len_o        = 8'h5A;
		end_o        = '0;
		access_o     = 1'b0;
	end

	// Kind 0 address, 1 length, 2 packet end (v[0] is CRC pass), 3 FIFO access
	task automatic send(input int kind, input logic [7:0] v);
		@(posedge clk_i);
		case (kind)
			0: begin
				addr_valid_o <= 1'b1;
				addr_o       <= v;
			end
			1: begin
				len_valid_o <= 1'b1;
				len_o       <= v;
			end
			2: end_o    <= '{valid: 1'b1, crc_pass: v[0]};
			default: access_o <= 1'b1;
		endcase
		@(posedge clk_i);
		addr_valid_o   <= 1'b0;
		len_valid_o    <= 1'b0;
		end_o.valid    <= 1'b0;
		access_o       <= 1'b0;
		addr_o         <= ~addr_o;
		len_o          <= ~len_o;
		end_o.crc_pass <= ~end_o.crc_pass;
		// Registered answers land at this edge; let them settle
		#1;
	endtask : send

endmodule : pkh_radio_model

/* File: tb/pkh_packet_cfg_bench.sv */
/*
 * Self-checking bench of the packet handler configuration block.
 * Assumes the package, design files and pkh_radio_model are compiled first.
 */
module pkh_packet_cfg_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 clk_i, rst_i, awvalid, wvalid, bready, arvalid, rready, standby;
	logic [7:0]           awaddr, araddr;
	logic [31:0]          wdata;
	logic [3:0]           wstrb;
	logic                 awready, wready, bvalid, arready, rvalid, av, lv, fa;
	logic [1:0]           bresp, rresp;
	logic [31:0]          rdata;
	logic [7:0]           aa, ll;
	logic [6:0]           plen;
	pkh_pkg::pkh_cfg_t    cfg;
	pkh_pkg::pkh_rx_end_t rx_end;
	logic                 acc, rej, lrej, flush, frd, fwr, irq;
	int                   miscompares = 0;
	int                   comparisons = 0;
	logic [7:0]           cv [4] = '{8'h00, 8'hB2, 8'h5C, 8'hEF};
	logic [7:0]           av_list [4] = '{8'h5A, 8'h00, 8'hFF, 8'h33};

	pkh_packet_cfg u_pkh_packet_cfg (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .cfg_o(cfg), .payload_len_o(plen), .rx_addr_valid_i(av), .rx_addr_i(aa),
		.addr_accept_o(acc), .addr_reject_o(rej), .rx_len_valid_i(lv), .rx_len_i(ll), .len_reject_o(lrej),
		.rx_end_i(rx_end), .fifo_flush_o(flush), .standby_i(standby), .fifo_access_i(fa),
		.fifo_rd_o(frd), .fifo_wr_o(fwr), .irq_o(irq));

	pkh_radio_model u_pkh_radio_model (.clk_i(clk_i), .addr_valid_o(av), .addr_o(aa), .len_valid_o(lv),
		.len_o(ll), .end_o(rx_end), .access_o(fa));

	////////////////////////////////////////////////////////////////////////////////
	// Clock, 25 ns period
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#(20000 * 25);
		miscompares++;
		tally_and_finish();
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// Address and data offered together; each dropped once its own ready is seen
	task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk_i);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h000000, d};
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk_i);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk_i); while (bvalid !== 1'b1);
		check(bresp, er, "write response");
		bready <= 1'b0;
	endtask : axi_write

	// Read one register and compare data and response
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_i); while (rvalid !== 1'b1);
		check(rdata, {24'h000000, ed}, "read data");
		check(rresp, er, "read response");
		rready <= 1'b0;
	endtask : rd_chk

	function automatic logic filt_ok(input logic [1:0] m, input logic [7:0] a);
		return m == 2'b00 || a == 8'h5A || (m[1] && a == 8'h00) || (m == 2'b11 && a == 8'hFF);
	endfunction : filt_ok

	////////////////////////////////////////////////////////////////////////////////
	// Test sequence
	initial begin
		{rst_i, awvalid, wvalid, bready, arvalid, rready, standby} = 7'h40;
		{awaddr, araddr, wdata, wstrb} = '0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values and bus refusal
		check(cfg, 8'hB4, "cfg reset");
		rd_chk(8'h78, 8'h48, pkh_pkg::RESP_OKAY);
		rd_chk(8'h7C, 8'h00, pkh_pkg::RESP_OKAY);
		rd_chk(8'h00, 8'h00, pkh_pkg::RESP_SLVERR);
		axi_write(8'h40, 8'h12, pkh_pkg::RESP_SLVERR);
		$display("test reset done");
		// Every format, preamble, whitening, CRC and filter code; bit 0 not writable
		foreach (cv[i]) begin
			axi_write(8'h78, cv[i], pkh_pkg::RESP_OKAY);
			check(cfg, {~cv[i][7], {1'b0, cv[i][6:5]} + 3'd1, cv[i][4:1]}, "cfg");
			rd_chk(8'h78, cv[i] & 8'hFE, pkh_pkg::RESP_OKAY);
		end
		$display("test config done");
		// Address filter in all four modes against node, zero, ones and other
		axi_write(8'h74, 8'h5A, pkh_pkg::RESP_OKAY);
		for (int m = 0; m < 4; m++) begin
			axi_write(8'h78, 8'h08 | 8'(m << 1), pkh_pkg::RESP_OKAY);
			foreach (av_list[j]) begin
				u_pkh_radio_model.send(0, av_list[j]);
				check(acc, filt_ok(2'(m), av_list[j]), "accept");
				check(rej, !filt_ok(2'(m), av_list[j]), "reject");
			end
		end
		$display("test filter done");
		// Length limit applies only in variable format, boundary value included
		axi_write(8'h70, 8'h0A, pkh_pkg::RESP_OKAY);
		check(plen, 7'h0A, "payload length");
		axi_write(8'h78, 8'h88, pkh_pkg::RESP_OKAY);
		u_pkh_radio_model.send(1, 8'h0A);
		check(lrej, 1'b0, "len at max");
		u_pkh_radio_model.send(1, 8'h0B);
		check(lrej, 1'b1, "len over max");
		axi_write(8'h78, 8'h08, pkh_pkg::RESP_OKAY);
		u_pkh_radio_model.send(1, 8'h0B);
		check(lrej, 1'b0, "len fixed");
		// Address rejects and the length overrun have left their sticky bits
		rd_chk(8'h80, 8'h0C, pkh_pkg::RESP_OKAY);
		$display("test length done");
		// CRC result, flush, status clear by one and masked interrupt
		axi_write(8'h80, 8'h0F, pkh_pkg::RESP_OKAY);
		rd_chk(8'h80, 8'h00, pkh_pkg::RESP_OKAY);
		axi_write(8'h84, 8'h02, pkh_pkg::RESP_OKAY);
		u_pkh_radio_model.send(2, 8'h00);
		check(flush, 1'b1, "flush on fail");
		check(irq, 1'b1, "irq on fail");
		rd_chk(8'h78, 8'h08, pkh_pkg::RESP_OKAY);
		rd_chk(8'h80, 8'h02, pkh_pkg::RESP_OKAY);
		axi_write(8'h80, 8'h02, pkh_pkg::RESP_OKAY);
		check(irq, 1'b0, "irq cleared");
		u_pkh_radio_model.send(2, 8'h01);
		check({flush, irq}, 2'b00, "pass quiet");
		rd_chk(8'h78, 8'h09, pkh_pkg::RESP_OKAY);
		axi_write(8'h7C, 8'h80, pkh_pkg::RESP_OKAY);
		u_pkh_radio_model.send(2, 8'h00);
		check(flush, 1'b0, "flush disabled");
		rd_chk(8'h78, 8'h08, pkh_pkg::RESP_OKAY);
		axi_write(8'h78, 8'h00, pkh_pkg::RESP_OKAY);
		u_pkh_radio_model.send(2, 8'h01);
		rd_chk(8'h78, 8'h00, pkh_pkg::RESP_OKAY);
		$display("test crc done");
		// Standby FIFO direction; host keeps the reserved bits at zero
		axi_write(8'h7C, 8'hC0, pkh_pkg::RESP_OKAY);
		rd_chk(8'h7C, 8'hC0, pkh_pkg::RESP_OKAY);
		standby <= 1'b1;
		u_pkh_radio_model.send(3, 8'h00);
		check({frd, fwr}, 2'b10, "standby read");
		axi_write(8'h7C, 8'h00, pkh_pkg::RESP_OKAY);
		u_pkh_radio_model.send(3, 8'h00);
		check({frd, fwr}, 2'b01, "standby write");
		$display("test standby done");
		tally_and_finish();
	end

endmodule : pkh_packet_cfg_bench
